/* File: hdl/dma_channel_register_set.v */
`include "dma_channel_map.vh"
module dma_channel_register_set (
    input  wire        ref_clk,
    input  wire        arst_n,
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire [1:0]  regWrHalf,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    input  wire [1:0]  xferRequestIn_n,
    output reg  [1:0]  xferStrobeOut,
    output reg  [1:0]  reqAcceptedOut,
    output wire [3:0]  chanActive
);
    // engine states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_READ = 2'h1;
    localparam [1:0] ST_WRITE = 2'h2;

    // per-channel register storage
    reg  [31:0] srcAddr_reg [0:3];   // next source address
    reg  [31:0] dstAddr_reg [0:3];   // next destination address
    reg  [23:0] xferCount_reg [0:3]; // remaining units
    reg  [31:0] chanCtrl_reg [0:3];  // channel control
    reg  [31:0] srcInit_reg;         // channel two reload value
    reg  [1:0]  reloadCnt_reg;       // channel two units since reload
    reg  [3:0]  endSeen_reg;         // end flag read as one
    reg  [1:0]  state_reg;           // engine state
    reg  [1:0]  actCh_reg;           // channel being served
    reg  [1:0]  reqMeta_reg;         // request sync stage one
    reg  [1:0]  reqSync_reg;         // request sync stage two
    reg  [1:0]  reqPrev_reg;         // for falling edge detect
    reg  [1:0]  edgeSeen_reg;        // latched falling edge
    reg  [1:0]  strobe_next;         // strobe, active high
    reg  [1:0]  accept_next;         // accept pulse, active high
    reg  [3:0]  reqPend;             // channels wanting service
    reg  [1:0]  pickCh;              // lowest pending channel

    // notes on the register window:
    // each channel owns four word slots, source first, control last
    // misaligned or unmapped reads return zero, writes there are dropped
    // half enables let software touch one 16-bit half of a word
    // the count keeps only 24 bits; its top byte has no storage at all
    // address and count carry no reset, so software must load them first
    // the control word is the only per-channel register of the window that resets

    // address decode
    wire        inRange = (regAddr >= `DMA_BASE_ADDR) &&
                          (regAddr <= `DMA_LAST_ADDR) && (regAddr[1:0] == 2'h0);
    wire [7:0]  offs    = regAddr - `DMA_BASE_ADDR;
    wire [1:0]  selCh   = offs[5:4];
    wire [1:0]  selSlot = offs[3:2];
    wire        swWr    = regWr && inRange;
    wire        unitDone = (state_reg == ST_WRITE);
    wire [31:0] actCtrl = chanCtrl_reg[actCh_reg];

    // merge the written halves into the old value
    function [31:0] mergeHalf;
        input [31:0] old;
        input [31:0] wd;
        input [1:0]  hen;
        begin
            mergeHalf = old;
            if (hen[0]) begin
                mergeHalf[15:0] = wd[15:0];
            end
            if (hen[1]) begin
                mergeHalf[31:16] = wd[31:16];
            end
        end
    endfunction

    // merge a count write; the top byte has no storage
    function [23:0] mergeCnt;
        input [23:0] old;
        input [31:0] wd;
        input [1:0]  hen;
        reg   [31:0] full;
        begin
            full     = mergeHalf({8'h00, old}, wd, hen);
            mergeCnt = full[23:0];
        end
    endfunction

    // writable control bits for a channel
    function [31:0] ctrlMask;
        input [1:0] ch;
        begin
            ctrlMask = `CTL_MASK_COMMON;
            if (ch[1] == 1'b0) begin
                ctrlMask = ctrlMask | `CTL_MASK_EXT;
            end
            if (ch == 2'h2) begin
                ctrlMask = ctrlMask | `CTL_MASK_RELOAD;
            end
            if (ch == 2'h3) begin
                ctrlMask = ctrlMask | `CTL_MASK_INDIR;
            end
        end
    endfunction

    // signed address step for a mode field
    function [31:0] addrStep;
        input [1:0] mode;
        input [1:0] size;
        input       indir;
        reg   [31:0] mag;
        begin
            mag = 32'h00000001;
            case (size)
                2'h1: mag = 32'h00000002;
                2'h2: mag = 32'h00000004;
                2'h3: mag = 32'h00000010;
                default: mag = 32'h00000001;
            endcase
            if (indir) begin
                mag = 32'h00000004;
            end
            case (mode)
                2'h1: addrStep = mag;
                2'h2: addrStep = ~mag + 32'h00000001;
                default: addrStep = 32'h00000000;
            endcase
        end
    endfunction

    // request source is an external pin
    function isExt;
        input [3:0] res;
        begin
            isExt = (res == `RES_EXT_DUAL) || (res == `RES_EXT_SGL_A) ||
                    (res == `RES_EXT_SGL_B);
        end
    endfunction

    // two-flop sync and edge history of request pins
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reqMeta_reg <= 2'h3;
            reqSync_reg <= 2'h3;
            reqPrev_reg <= 2'h3;
        end else begin
            reqMeta_reg <= xferRequestIn_n;
            reqSync_reg <= reqMeta_reg;
            reqPrev_reg <= reqSync_reg;
        end
    end

    // pending requests and fixed priority pick
    // channels 2 and 3 have no pins, so only auto requests reach them
    always @* begin : pend_pick
        integer i;
        i       = 0;
        reqPend = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (chanCtrl_reg[i][`CTL_ENABLE] && !chanCtrl_reg[i][`CTL_END_FLAG]) begin
                if (chanCtrl_reg[i][`CTL_RES_LO+3:`CTL_RES_LO] == `RES_AUTO) begin
                    reqPend[i] = 1'b1;
                end else if (i < 2 && isExt(chanCtrl_reg[i][`CTL_RES_LO+3:`CTL_RES_LO])) begin
                    // level or latched falling edge
                    reqPend[i] = chanCtrl_reg[i][`CTL_XFER_REQUEST_IN_EDGE] ? edgeSeen_reg[i & 1]
                                                                  : !reqSync_reg[i & 1];
                end
            end
        end
        pickCh = reqPend[0] ? 2'h0 : reqPend[1] ? 2'h1 : reqPend[2] ? 2'h2 : 2'h3;
    end

    // engine sequence: read phase then write phase
    // a new edge in the grant cycle wins, so no falling edge is lost
    always @(posedge ref_clk or negedge arst_n) begin : engine_seq
        integer i;
        if (!arst_n) begin
            state_reg    <= ST_IDLE;
            actCh_reg    <= 2'h0;
            edgeSeen_reg <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                if (reqPrev_reg[i] && !reqSync_reg[i]) begin
                    edgeSeen_reg[i] <= 1'b1;
                end else if (state_reg == ST_IDLE && reqPend != 4'h0 && pickCh == i) begin
                    edgeSeen_reg[i] <= 1'b0;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (reqPend != 4'h0) begin
                        actCh_reg <= pickCh;
                        state_reg <= ST_READ;
                    end
                end
                ST_READ: begin
                    state_reg <= ST_WRITE;
                end
                ST_WRITE: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign chanActive = (state_reg == ST_IDLE) ? 4'h0 : (4'h1 << actCh_reg);

    // strobe and accept levels before polarity
    always @* begin
        strobe_next = 2'h0;
        accept_next = 2'h0;
        if (state_reg == ST_IDLE && reqPend[1:0] != 2'h0 && pickCh[1] == 1'b0) begin
            accept_next[pickCh[0]] = 1'b1;
        end
        if (state_reg != ST_IDLE && actCh_reg[1] == 1'b0 &&
            isExt(actCtrl[`CTL_RES_LO+3:`CTL_RES_LO])) begin
            if (actCtrl[`CTL_RES_LO+3:`CTL_RES_LO] != `RES_EXT_DUAL) begin
                strobe_next[actCh_reg[0]] = 1'b1;
            end else if (actCtrl[`CTL_STROBE_CYC]) begin
                strobe_next[actCh_reg[0]] = (state_reg == ST_WRITE);
            end else begin
                strobe_next[actCh_reg[0]] = (state_reg == ST_READ);
            end
        end
    end

    // pin outputs with per-channel polarity
    // reset drives both pins high, the idle level of the default polarity
    always @(posedge ref_clk or negedge arst_n) begin : pin_out
        integer i;
        if (!arst_n) begin
            xferStrobeOut  <= 2'h3;
            reqAcceptedOut <= 2'h3;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                xferStrobeOut[i]  <= chanCtrl_reg[i][`CTL_STROBE_POL] ? strobe_next[i]
                                                                     : !strobe_next[i];
                reqAcceptedOut[i] <= chanCtrl_reg[i][`CTL_ACCEPT_POL] ? accept_next[i]
                                                                     : !accept_next[i];
            end
        end
    end

    // control registers and end flag
    // the end flag is outside every write mask; only the engine sets it
    // and only a qualified zero write clears it, the set winning a tie
    always @(posedge ref_clk or negedge arst_n) begin : ctrl_regs
        integer i;
        if (!arst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                chanCtrl_reg[i] <= `CTL_RESET_VAL;
            end
            endSeen_reg <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (swWr && selSlot == `DMA_SLOT_CTRL && selCh == i) begin
                    chanCtrl_reg[i] <= (chanCtrl_reg[i] & ~ctrlMask(i[1:0])) |
                        (mergeHalf(chanCtrl_reg[i], regWrData, regWrHalf) & ctrlMask(i[1:0]));
                    if (unitDone && actCh_reg == i &&
                        xferCount_reg[i] == 24'h000001) begin
                        chanCtrl_reg[i][`CTL_END_FLAG] <= 1'b1;
                    end else if (regWrHalf[0] && !regWrData[`CTL_END_FLAG] &&
                                 endSeen_reg[i]) begin
                        chanCtrl_reg[i][`CTL_END_FLAG] <= 1'b0;
                    end
                end else if (unitDone && actCh_reg == i &&
                             xferCount_reg[i] == 24'h000001) begin
                    chanCtrl_reg[i][`CTL_END_FLAG] <= 1'b1;
                end
                // arm the clear once the flag is seen set
                if (regRd && inRange && selSlot == `DMA_SLOT_CTRL && selCh == i &&
                    chanCtrl_reg[i][`CTL_END_FLAG]) begin
                    endSeen_reg[i] <= 1'b1;
                end else if (!chanCtrl_reg[i][`CTL_END_FLAG]) begin
                    endSeen_reg[i] <= 1'b0;
                end
            end
        end
    end

    // address and count registers, no reset, software write wins
    // kept without reset so their contents survive a reset pulse
    always @(posedge ref_clk) begin : addr_regs
        integer i;
        for (i = 0; i < 4; i = i + 1) begin
            if (swWr && selSlot == `DMA_SLOT_SRC && selCh == i) begin
                srcAddr_reg[i] <= mergeHalf(srcAddr_reg[i], regWrData, regWrHalf);
            end else if (unitDone && actCh_reg == i) begin
                if (i == 2 && chanCtrl_reg[2][`CTL_RELOAD] &&
                    reloadCnt_reg == `RELOAD_PERIOD) begin
                    srcAddr_reg[i] <= srcInit_reg;
                end else begin
                    srcAddr_reg[i] <= srcAddr_reg[i] +
                        addrStep(chanCtrl_reg[i][`CTL_SRC_MODE_LO+1:`CTL_SRC_MODE_LO],
                                 chanCtrl_reg[i][`CTL_SIZE_LO+1:`CTL_SIZE_LO],
                                 chanCtrl_reg[i][`CTL_INDIRECT]);
                end
            end
            if (swWr && selSlot == `DMA_SLOT_DST && selCh == i) begin
                dstAddr_reg[i] <= mergeHalf(dstAddr_reg[i], regWrData, regWrHalf);
            end else if (unitDone && actCh_reg == i) begin
                dstAddr_reg[i] <= dstAddr_reg[i] +
                    addrStep(chanCtrl_reg[i][`CTL_DST_MODE_LO+1:`CTL_DST_MODE_LO],
                             chanCtrl_reg[i][`CTL_SIZE_LO+1:`CTL_SIZE_LO], 1'b0);
            end
            if (swWr && selSlot == `DMA_SLOT_CNT && selCh == i) begin
                xferCount_reg[i] <= mergeCnt(xferCount_reg[i], regWrData, regWrHalf);
            end else if (unitDone && actCh_reg == i) begin
                // zero wraps, giving the maximum count
                xferCount_reg[i] <= xferCount_reg[i] - 24'h000001;
            end
        end
        // channel two reload bookkeeping
        if (swWr && selSlot == `DMA_SLOT_SRC && selCh == 2'h2) begin
            srcInit_reg   <= mergeHalf(srcAddr_reg[2], regWrData, regWrHalf);
            reloadCnt_reg <= 2'h0;
        end else if (unitDone && actCh_reg == 2'h2) begin
            reloadCnt_reg <= reloadCnt_reg + 2'h1;
        end
    end

    // read data one cycle after the strobe
    // the value then holds until the next read strobe
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 32'h00000000;
        end else if (regRd && inRange) begin
            case (selSlot)
                `DMA_SLOT_SRC: regRdData <= srcAddr_reg[selCh];
                `DMA_SLOT_DST: regRdData <= dstAddr_reg[selCh];
                `DMA_SLOT_CNT: regRdData <= {8'h00, xferCount_reg[selCh]};
                default:       regRdData <= chanCtrl_reg[selCh];
            endcase
        end else if (regRd) begin
            regRdData <= 32'h00000000;
        end
    end
endmodule // dma_channel_register_set

/* File: hdl/dma_channel_map.vh */
`ifndef DMA_CHANNEL_MAP_VH
`define DMA_CHANNEL_MAP_VH
// register window, byte addresses
`define DMA_BASE_ADDR     8'h20
`define DMA_LAST_ADDR     8'h5c
`define DMA_CHAN_STRIDE   8'h10
// register slot within one channel
`define DMA_SLOT_SRC      2'h0
`define DMA_SLOT_DST      2'h1
`define DMA_SLOT_CNT      2'h2
`define DMA_SLOT_CTRL     2'h3
// control field positions
`define CTL_ENABLE        0
`define CTL_END_FLAG      1
`define CTL_XFER_REQUEST_IN_EDGE     6
`define CTL_SIZE_LO       3
`define CTL_RES_LO        8
`define CTL_SRC_MODE_LO   12
`define CTL_DST_MODE_LO   14
`define CTL_STROBE_POL    16
`define CTL_STROBE_CYC    17
`define CTL_ACCEPT_POL    18
`define CTL_RELOAD        19
`define CTL_INDIRECT      20
// writable bit masks
`define CTL_MASK_COMMON   32'h0000ff3d
`define CTL_MASK_EXT      32'h00070040
`define CTL_MASK_RELOAD   32'h00080000
`define CTL_MASK_INDIR    32'h00100000
`define CTL_RESET_VAL     32'h00000000
`define CNT_MASK          32'h00ffffff
// request source codes
`define RES_EXT_DUAL      4'h0
`define RES_EXT_SGL_A     4'h2
`define RES_EXT_SGL_B     4'h3
`define RES_AUTO          4'h4
// transfers between source reloads
`define RELOAD_PERIOD     2'h3
`endif

/* File: sim/dma_channel_register_set_sva.sv */
module dma_channel_register_set_sva (
    input logic        ref_clk,
    input logic        arst_n,
    input logic [7:0]  regAddr,
    input logic        regWr,
    input logic        regRd,
    input logic [31:0] regRdData,
    input logic [1:0]  xferStrobeOut,
    input logic [1:0]  reqAcceptedOut,
    input logic [3:0]  chanActive
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    // control slot read one cycle back
    sequence ctlRead;
        $past(regRd) && $past(regAddr[3:0]) == 4'hc;
    endsequence
    // one unit: two busy cycles, then idle
    sequence unitBusy;
        chanActive[0] [*2] ##1 !chanActive[0];
    endsequence
    unit_three_cycles_a: assert property ($rose(chanActive[0]) |-> unitBusy)
        else $error("unit length wrong");
    accept_on_grant_a: assert property ($rose(chanActive[0]) |-> $changed(reqAcceptedOut[0]))
        else $error("no accept pulse at grant");
    accept_one_cycle_a: assert property ($rose(chanActive[0]) |=> $changed(reqAcceptedOut[0]))
        else $error("accept pulse not one cycle");
    strobe_in_unit_a: assert property ($rose(chanActive[1]) |-> ##[1:2] $changed(xferStrobeOut[1]))
        else $error("no strobe during unit");
    strobe_quiet_a: assert property ($changed(xferStrobeOut[0]) |-> chanActive[0]
        || $past(chanActive[0]) || $past(chanActive[0], 2) || $past(regWr) || $past(regWr, 2))
        else $error("strobe moved outside a unit");
    cnt_top_zero_a: assert property ($past(regRd) && $past(regAddr[3:0]) == 4'h8
        |-> regRdData[31:24] == 8'h00) else $error("count top byte not zero");
    ctl_reserved_a: assert property (ctlRead |-> regRdData[31:21] == 11'h000)
        else $error("reserved control bits set");
    ext_bits_low_a: assert property (ctlRead ##0 $past(regAddr[6])
        |-> {regRdData[18:16], regRdData[6]} == 4'h0) else $error("pin bits in channel 2 or 3");
    reload_ch2_only_a: assert property (ctlRead ##0 $past(regAddr) != 8'h4c
        |-> !regRdData[19]) else $error("reload bit outside channel 2");
    indirect_ch3_only_a: assert property (ctlRead ##0 $past(regAddr) != 8'h5c
        |-> !regRdData[20]) else $error("indirect bit outside channel 3");
endmodule // dma_channel_register_set_sva

bind dma_channel_register_set dma_channel_register_set_sva chk (.ref_clk(ref_clk),
    .arst_n(arst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .xferStrobeOut(xferStrobeOut), .reqAcceptedOut(reqAcceptedOut), .chanActive(chanActive));

/* File: sim/io_request_device.sv */
module io_request_device (
    input  logic clk,
    input  logic rstN,
    input  int   units,
    input  logic acceptHigh,
    input  logic strobeHigh,
    input  logic acceptedPin,
    input  logic strobePin,
    output logic reqN,
    output int   nAccepted,
    output int   nStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic accPrev; // last accepted level
    // requests while units are owed; released line reads pulled high
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            reqN      <= 1'b1;
            accPrev   <= 1'b1;
            nAccepted <= 0;
            nStrobe   <= 0;
        end else begin
            reqN    <= !(nAccepted < units);
            accPrev <= acceptedPin;
            // count accept pulses by their leading edge
            if (acceptedPin == acceptHigh && accPrev != acceptHigh)
                nAccepted <= nAccepted + 1;
            // count active strobe cycles
            if (strobePin == strobeHigh)
                nStrobe <= nStrobe + 1;
        end
    end
endmodule // io_request_device

/* File: sim/dma_channel_register_set_tb.sv */
module dma_channel_register_set_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData, rdVal;
    logic [1:0]  regWrHalf = 2'h3, xferRequestIn_n, xferStrobeOut, reqAcceptedOut;
    logic [3:0]  chanActive;
    int          n_errors = 0, n_tests = 0, units0 = 0, units1 = 0;
    int          nAcc0, nAcc1, nStb0, nStb1;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] h; logic [31:0] e;} row_t;
    row_t rows[10] = '{
        '{8'h20, 32'hffffffff, 2'h3, 32'hffffffff},
        '{8'h24, 32'h12345678, 2'h3, 32'h12345678},
        '{8'h24, 32'h0000abcd, 2'h1, 32'h1234abcd},
        '{8'h28, 32'hffffffff, 2'h3, 32'h00ffffff},
        '{8'h2c, 32'hffffffe7, 2'h3, 32'h0007ff65},
        '{8'h3c, 32'hffffffe7, 2'h3, 32'h0007ff65},
        '{8'h4c, 32'hffffffe7, 2'h3, 32'h0008ff25},
        '{8'h5c, 32'hffffffe7, 2'h3, 32'h0010ff25},
        '{8'h60, 32'hffffffff, 2'h3, 32'h00000000},
        '{8'h22, 32'hffffffff, 2'h3, 32'h00000000}};

    dma_channel_register_set dut (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrHalf(regWrHalf), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .xferRequestIn_n(xferRequestIn_n),
        .xferStrobeOut(xferStrobeOut), .reqAcceptedOut(reqAcceptedOut), .chanActive(chanActive));
    // channel 0 device: accept active high, strobe active low
    io_request_device dev0 (.clk(ref_clk), .rstN(arst_n), .units(units0), .acceptHigh(1'b1),
        .strobeHigh(1'b0), .acceptedPin(reqAcceptedOut[0]), .strobePin(xferStrobeOut[0]),
        .reqN(xferRequestIn_n[0]), .nAccepted(nAcc0), .nStrobe(nStb0));
    // channel 1 device: both active low
    io_request_device dev1 (.clk(ref_clk), .rstN(arst_n), .units(units1), .acceptHigh(1'b0),
        .strobeHigh(1'b0), .acceptedPin(reqAcceptedOut[1]), .strobePin(xferStrobeOut[1]),
        .reqN(xferRequestIn_n[1]), .nAccepted(nAcc1), .nStrobe(nStb1));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one write cycle, idle cycle after so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] h = 2'h3);
        regAddr   <= a;
        regWrData <= d;
        regWrHalf <= h;
        regWr     <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // one read cycle, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData;
        @(posedge ref_clk);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string what);
        rd(a);
        chk(rdVal, e, what);
    endtask
    // poll the end flag, bounded
    task automatic waitEnd(input logic [7:0] a);
        int i;
        for (i = 0; i < 100; i++) begin
            rd(a);
            if (rdVal[1] === 1'b1)
                break;
        end
        if (i == 100) begin
            n_errors++;
            $display("FAIL %0t end flag never set", $time);
            complete_run();
        end
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].h);
            rdChk(rows[i].a, rows[i].e, "register row");
        end
        $display("register table done");
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        rdChk(8'h2c, 32'h0, "control cleared");
        rdChk(8'h5c, 32'h0, "control cleared");
        rdChk(8'h20, 32'hffffffff, "source kept");
        $display("reset test done");
        // channel 0, external dual address, longword increment
        wr(8'h20, 32'h100);
        wr(8'h24, 32'h200);
        wr(8'h28, 32'h2);
        wr(8'h2c, 32'h00045011);
        units0 <= 2;
        waitEnd(8'h2c);
        rdChk(8'h20, 32'h108, "source next");
        rdChk(8'h24, 32'h208, "destination next");
        rdChk(8'h28, 32'h0, "count left");
        wr(8'h2c, 32'h00045010);
        rdChk(8'h2c, 32'h00045010, "end flag cleared");
        chk(nAcc0, 2, "accept pulses");
        chk(nStb0, 2, "read phase strobes");
        $display("dual transfer done");
        // channel 1, single address, write phase selected
        wr(8'h30, 32'h400);
        wr(8'h38, 32'h1);
        wr(8'h3c, 32'h00020211);
        units1 <= 1;
        waitEnd(8'h3c);
        rdChk(8'h38, 32'h0, "one unit run");
        chk(nStb1, 2, "single strobes");
        chk(nAcc1, 1, "accept low");
        $display("single transfer done");
        // channel 2, auto request, source reload
        wr(8'h40, 32'h300);
        wr(8'h48, 32'h5);
        wr(8'h4c, 32'h00081411);
        waitEnd(8'h4c);
        rdChk(8'h40, 32'h304, "source reloaded");
        rdChk(8'h48, 32'h0, "count done");
        $display("reload transfer done");
        // channel 0 falling-edge detect: one edge gives one unit only
        wr(8'h28, 32'h2);
        wr(8'h2c, 32'h00045051);
        units0 <= 3;
        repeat (30) @(posedge ref_clk);
        rdChk(8'h28, 32'h1, "one unit per edge");
        chk(nAcc0, 3, "edge accept");
        $display("edge request done");
        // channel 3 indirect: source steps by 4, destination decrements
        wr(8'h50, 32'h500);
        wr(8'h54, 32'h600);
        wr(8'h58, 32'h2);
        wr(8'h5c, 32'h00109401);
        waitEnd(8'h5c);
        rdChk(8'h50, 32'h508, "indirect source step");
        rdChk(8'h54, 32'h5fe, "destination down");
        rdChk(8'h58, 32'h0, "indirect count done");
        $display("indirect transfer done");
        complete_run();
    end
endmodule // dma_channel_register_set_tb
